// ---- hdl/thtr_pkg.sv ----
// Purpose: shared constants and types of the thermal result register block
// Assumes: byte-wide register space reached over the two-wire serial port
// Notes:   result words are sign plus 15 result bits, stored as one 16-bit word

`default_nettype none

package thtr_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] THTR_OFF_BUS_HI  = 8'h22;
   localparam logic [7:0] THTR_OFF_BUS_LO  = 8'h23;
   localparam logic [7:0] THTR_OFF_BATT_HI = 8'h24;
   localparam logic [7:0] THTR_OFF_BATT_LO = 8'h25;
   localparam logic [7:0] THTR_OFF_DIE_HI  = 8'h26;
   localparam logic [7:0] THTR_OFF_DIE_LO  = 8'h27;
   localparam logic [7:0] THTR_UNMAPPED    = 8'h00;

   // ==========================================================
   // result channels and field layout
   localparam int         THTR_NUM_CH   = 3;
   localparam logic [1:0] THTR_CH_BUS   = 2'h0;
   localparam logic [1:0] THTR_CH_BATT  = 2'h1;
   localparam logic [1:0] THTR_CH_DIE   = 2'h2;
   localparam int         THTR_SIGN_POS = 15;
   localparam int         THTR_HI_POS   = 8;

   // ==========================================================
   // reset values; undefined at power-up, zero chosen here
   localparam logic [15:0] THTR_RESULT_RESET = 16'h0000;

   // ==========================================================
   // scaling: ratio codes are 1024 steps of 0.09766 % full scale,
   // die code is 0.5 degC per step above a 5 degC offset
   localparam logic [10:0] THTR_RATIO_FULL_CODE = 11'h400;
   localparam logic [16:0] THTR_DIE_OFFSET_HALF = 17'h0000a;

   // ==========================================================
   // serial port
   localparam logic [3:0] THTR_BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] THTR_DEV_ADDR      = 7'h55; // arbitrary value

   typedef struct packed {
      logic        valid;
      logic [1:0]  chan;
      logic [15:0] code;
   } thtr_result_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } thtr_pins_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK,
      ST_RX,
      ST_TX,
      ST_MACK
   } thtr_state_type;

endpackage

`default_nettype wire

// ---- hdl/thtr_sync2.sv ----
// Purpose: two-flop synchroniser for the serial port pins
// Assumes: pins idle high
// Notes:   first stage feeds only the second stage

`timescale 1ns/10ps
`default_nettype none

module thtr_sync2 (
   input  wire logic                   mclk,
   input  wire logic                   rstn,
   input  wire thtr_pkg::thtr_pins_type pinsIn,
   output var  thtr_pkg::thtr_pins_type pinsOut
);

   thtr_pkg::thtr_pins_type meta_reg;
   thtr_pkg::thtr_pins_type sync_reg;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= 2'h3;
         sync_reg <= 2'h3;
      end
      else
      begin
         meta_reg <= pinsIn;
         sync_reg <= meta_reg;
      end
   end

   assign pinsOut = sync_reg;

endmodule

`default_nettype wire

// ---- hdl/thtr_result_regs.sv ----
// Purpose: thermistor and die temperature result registers behind the serial port
// Assumes: converter results arrive on mclk; regReset comes from the control registers
// Notes:   writes to this space are acknowledged but change nothing
//
// Summary of operation
// - bus thermistor high byte: sign, bits 14-8
// - bus thermistor low byte: bits 7-0
// - bus code is ratio of output-side voltage
// - bus step 0.09766 percent, bits 8/9
// - battery thermistor result in high, low bytes
// - battery code same ratio step as bus
// - die temperature result in high, low bytes
// - die temp is 5 degC plus half-degree steps
// - high byte bit 7 is two's complement sign
// - soft register reset clears all result bytes

`timescale 1ns/10ps
`default_nettype none

module thtr_result_regs (
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   input  wire logic                     regReset,
   input  wire thtr_pkg::thtr_result_type resultIn,
   input  wire logic                     sclIn,
   input  wire logic                     sdaIn,
   output logic                          sdaOut,
   output logic                          sdaOutEnN,
   output logic [16:0]                   dieTempHalfDeg
);

   // ==========================================================
   // register read decode
   function automatic logic [7:0] regByte(
      input logic [7:0]  off,
      input logic [15:0] res [thtr_pkg::THTR_NUM_CH]
   );
      case (off)
         thtr_pkg::THTR_OFF_BUS_HI:  regByte = res[thtr_pkg::THTR_CH_BUS][15:8];
         thtr_pkg::THTR_OFF_BUS_LO:  regByte = res[thtr_pkg::THTR_CH_BUS][7:0];
         thtr_pkg::THTR_OFF_BATT_HI: regByte = res[thtr_pkg::THTR_CH_BATT][15:8];
         thtr_pkg::THTR_OFF_BATT_LO: regByte = res[thtr_pkg::THTR_CH_BATT][7:0];
         thtr_pkg::THTR_OFF_DIE_HI:  regByte = res[thtr_pkg::THTR_CH_DIE][15:8];
         thtr_pkg::THTR_OFF_DIE_LO:  regByte = res[thtr_pkg::THTR_CH_DIE][7:0];
         default:                    regByte = thtr_pkg::THTR_UNMAPPED;
      endcase
   endfunction

   // ==========================================================
   // declarations
   logic [15:0]               result_reg [thtr_pkg::THTR_NUM_CH];
   logic [16:0]               dieTemp_reg;
   thtr_pkg::thtr_pins_type   pinSync;
   logic                      sclPrev_reg;
   logic                      sdaPrev_reg;
   thtr_pkg::thtr_state_type  state_reg;
   logic [3:0]                bitCnt_reg;
   logic [7:0]                shift_reg;
   logic [7:0]                txShift_reg;
   logic [7:0]                ptr_reg;
   logic                      isRead_reg;
   logic                      havePtr_reg;
   logic                      masterNack_reg;
   logic                      sdaOutEnN_reg;
   logic                      sdaOut_reg;
   logic                      sclS;
   logic                      sdaS;
   logic                      startCond;
   logic                      stopCond;
   logic                      sclRise;
   logic                      sclFall;
   logic                      byteDone;
   logic                      ignoredWrite;
   logic [7:0]                nextTx;
   logic [15:0]               capCode;
   logic [7:0]                capHi;
   logic [7:0]                capLo;
   logic [16:0]               capExt;
   logic                      capBus;
   logic                      capBatt;
   logic                      capDie;

   // ==========================================================
   // pin synchronisation and bus conditions
   thtr_sync2 u_sync (
      .mclk    (mclk),
      .rstn    (rstn),
      .pinsIn  ({sclIn, sdaIn}),
      .pinsOut (pinSync)
   );

   assign sclS = pinSync.scl;
   assign sdaS = pinSync.sda;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end
      else
      begin
         sclPrev_reg <= sclS;
         sdaPrev_reg <= sdaS;
      end
   end

   assign startCond    = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
   assign stopCond     = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
   assign sclRise      = sclS && !sclPrev_reg;
   assign sclFall      = !sclS && sclPrev_reg;
   assign byteDone     = (bitCnt_reg == thtr_pkg::THTR_BITS_PER_BYTE);
   assign ignoredWrite = sclFall && (state_reg == thtr_pkg::ST_RX) && byteDone && havePtr_reg;
   assign nextTx       = regByte(ptr_reg, result_reg);

   // ==========================================================
   // result storage
   assign capCode = resultIn.code;
   assign capHi   = resultIn.code[15:8];
   assign capLo   = resultIn.code[7:0];
   assign capExt  = {resultIn.code[thtr_pkg::THTR_SIGN_POS], resultIn.code};
   assign capBus  = resultIn.valid && (resultIn.chan == thtr_pkg::THTR_CH_BUS);
   assign capBatt = resultIn.valid && (resultIn.chan == thtr_pkg::THTR_CH_BATT);
   assign capDie  = resultIn.valid && (resultIn.chan == thtr_pkg::THTR_CH_DIE);

   // codes are kept raw: ratio codes stay in output-side-voltage units
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < thtr_pkg::THTR_NUM_CH; i++)
         begin
            result_reg[i] <= thtr_pkg::THTR_RESULT_RESET;
         end
      end
      else if (regReset)
      begin
         // soft reset beats a result landing in the same cycle
         for (int i = 0; i < thtr_pkg::THTR_NUM_CH; i++)
         begin
            result_reg[i] <= thtr_pkg::THTR_RESULT_RESET;
         end
      end
      else if (capBus || capBatt || capDie)
      begin
         result_reg[resultIn.chan] <= resultIn.code;
      end
   end

   // die code in half degrees, offset added so host can skip it
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         dieTemp_reg <= thtr_pkg::THTR_DIE_OFFSET_HALF;
      end
      else
      begin
         dieTemp_reg <= {result_reg[thtr_pkg::THTR_CH_DIE][thtr_pkg::THTR_SIGN_POS],
                         result_reg[thtr_pkg::THTR_CH_DIE]}
                        + thtr_pkg::THTR_DIE_OFFSET_HALF;
      end
   end

   // ==========================================================
   // serial port protocol
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg      <= thtr_pkg::ST_IDLE;
         bitCnt_reg     <= 4'h0;
         shift_reg      <= 8'h00;
         txShift_reg    <= 8'h00;
         ptr_reg        <= 8'h00;
         isRead_reg     <= 1'b0;
         havePtr_reg    <= 1'b0;
         masterNack_reg <= 1'b0;
         sdaOutEnN_reg  <= 1'b1;
      end
      else if (startCond)
      begin
         state_reg     <= thtr_pkg::ST_ADDR;
         bitCnt_reg    <= 4'h0;
         havePtr_reg   <= 1'b0;
         sdaOutEnN_reg <= 1'b1;
      end
      else if (stopCond)
      begin
         state_reg     <= thtr_pkg::ST_IDLE;
         sdaOutEnN_reg <= 1'b1;
      end
      else if (sclRise)
      begin
         case (state_reg)
            thtr_pkg::ST_ADDR, thtr_pkg::ST_RX:
            begin
               shift_reg  <= {shift_reg[6:0], sdaS};
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            thtr_pkg::ST_TX:
            begin
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            thtr_pkg::ST_MACK:
            begin
               masterNack_reg <= sdaS;
            end
            default:
            begin
            end
         endcase
      end
      else if (sclFall)
      begin
         case (state_reg)
            thtr_pkg::ST_ADDR:
            begin
               if (byteDone && (shift_reg[7:1] == thtr_pkg::THTR_DEV_ADDR))
               begin
                  isRead_reg    <= shift_reg[0];
                  state_reg     <= thtr_pkg::ST_ACK;
                  sdaOutEnN_reg <= 1'b0;
               end
               else if (byteDone)
               begin
                  state_reg <= thtr_pkg::ST_IDLE;
               end
            end
            thtr_pkg::ST_ACK:
            begin
               bitCnt_reg <= 4'h0;
               if (isRead_reg)
               begin
                  txShift_reg   <= nextTx;
                  sdaOutEnN_reg <= nextTx[7];
                  ptr_reg       <= ptr_reg + 8'h01;
                  state_reg     <= thtr_pkg::ST_TX;
               end
               else
               begin
                  sdaOutEnN_reg <= 1'b1;
                  state_reg     <= thtr_pkg::ST_RX;
               end
            end
            thtr_pkg::ST_RX:
            begin
               if (byteDone)
               begin
                  // first byte sets the pointer; data bytes only advance it
                  if (!havePtr_reg)
                  begin
                     ptr_reg     <= shift_reg;
                     havePtr_reg <= 1'b1;
                  end
                  else
                  begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
                  state_reg     <= thtr_pkg::ST_ACK;
                  sdaOutEnN_reg <= 1'b0;
               end
            end
            thtr_pkg::ST_TX:
            begin
               if (byteDone)
               begin
                  sdaOutEnN_reg <= 1'b1;
                  state_reg     <= thtr_pkg::ST_MACK;
               end
               else
               begin
                  // open drain: release for a one, pull low for a zero
                  sdaOutEnN_reg <= txShift_reg[6];
                  txShift_reg   <= {txShift_reg[6:0], 1'b0};
               end
            end
            thtr_pkg::ST_MACK:
            begin
               bitCnt_reg <= 4'h0;
               if (masterNack_reg)
               begin
                  state_reg <= thtr_pkg::ST_IDLE;
               end
               else
               begin
                  txShift_reg   <= nextTx;
                  sdaOutEnN_reg <= nextTx[7];
                  ptr_reg       <= ptr_reg + 8'h01;
                  state_reg     <= thtr_pkg::ST_TX;
               end
            end
            default:
            begin
               state_reg <= thtr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // data line only ever pulls low
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sdaOut_reg <= 1'b0;
      end
      else
      begin
         sdaOut_reg <= 1'b0;
      end
   end

   assign sdaOut         = sdaOut_reg;
   assign sdaOutEnN      = sdaOutEnN_reg;
   assign dieTempHalfDeg = dieTemp_reg;

   // ==========================================================
   // checks
   a_bus_hi_byte: assert property (
      @(posedge mclk) disable iff (!rstn)
      capBus && !regReset |=> regByte(thtr_pkg::THTR_OFF_BUS_HI, result_reg) == $past(capHi))
   else $error("bus high byte does not hold captured sign and upper bits");

   a_bus_lo_byte: assert property (
      @(posedge mclk) disable iff (!rstn)
      capBus && !regReset |=> regByte(thtr_pkg::THTR_OFF_BUS_LO, result_reg) == $past(capLo))
   else $error("bus low byte does not hold captured low bits");

   a_batt_bytes: assert property (
      @(posedge mclk) disable iff (!rstn)
      capBatt && !regReset |=>
         {regByte(thtr_pkg::THTR_OFF_BATT_HI, result_reg),
          regByte(thtr_pkg::THTR_OFF_BATT_LO, result_reg)} == $past(capCode))
   else $error("battery result bytes differ from captured code");

   a_die_bytes: assert property (
      @(posedge mclk) disable iff (!rstn)
      capDie && !regReset |=>
         {regByte(thtr_pkg::THTR_OFF_DIE_HI, result_reg),
          regByte(thtr_pkg::THTR_OFF_DIE_LO, result_reg)} == $past(capCode))
   else $error("die result bytes differ from captured code");

   a_die_scale: assert property (
      @(posedge mclk) disable iff (!rstn)
      capDie && !regReset ##1 !regReset && !capDie |=>
         dieTemp_reg == 17'($past(capExt, 2) + thtr_pkg::THTR_DIE_OFFSET_HALF))
   else $error("die temperature not offset plus half-degree code");

   a_sign_bit: assert property (
      @(posedge mclk) disable iff (!rstn)
      capDie && !regReset && capCode[15] |=>
         regByte(thtr_pkg::THTR_OFF_DIE_HI, result_reg) >= 8'h80)
   else $error("negative result does not set high byte bit 7");

   a_soft_reset: assert property (
      @(posedge mclk) disable iff (!rstn)
      regReset |=> result_reg[0] == thtr_pkg::THTR_RESULT_RESET
                && result_reg[1] == thtr_pkg::THTR_RESULT_RESET
                && result_reg[2] == thtr_pkg::THTR_RESULT_RESET)
   else $error("soft reset left a result byte set");

   a_write_ignored: assert property (
      @(posedge mclk) disable iff (!rstn)
      ignoredWrite && !resultIn.valid && !regReset |=>
         $stable(result_reg[0]) && $stable(result_reg[1]) && $stable(result_reg[2]))
   else $error("host write changed a stored result");

endmodule

`default_nettype wire

// ---- sim/thtr_host_model.sv ----
// Purpose: serial bus host that addresses the result register block
// Assumes: data line resolved outside with a pull-up; host moves on falling mclk
// Notes:   five-cycle phases keep setup and hold above four mclk

`timescale 1ns/10ps
`default_nettype none

module thtr_host_model (
   input  wire logic mclk,
   input  wire logic sdaLine,
   output var  logic sclPin,
   output var  logic sdaDriveN
);
   initial
   begin
      sclPin    = 1'b1;
      sdaDriveN = 1'b1;
   end

   // ==========================================================
   // bus phases
   task automatic halfPhase();
      repeat (5) @(negedge mclk);
   endtask

   // doubles as repeated start: data released before clock rises
   task automatic startCond();
      sdaDriveN = 1'b1;
      halfPhase();
      sclPin = 1'b1;
      halfPhase();
      sdaDriveN = 1'b0;
      halfPhase();
      sclPin = 1'b0;
      halfPhase();
   endtask

   task automatic stopCond();
      sdaDriveN = 1'b0;
      halfPhase();
      sclPin = 1'b1;
      halfPhase();
      sdaDriveN = 1'b1;
      halfPhase();
   endtask

   // sample at end of high phase, as clock falls; target moves only after the falling edge
   task automatic bitXfer(input logic b, output logic r);
      sdaDriveN = b;
      halfPhase();
      sclPin = 1'b1;
      halfPhase();
      r = sdaLine;
      sclPin = 1'b0;
      halfPhase();
   endtask

   task automatic xferByte(input  logic [7:0] tx,
                           input  logic       lastBit,
                           output logic [7:0] rx,
                           output logic       ackSeen);
      for (int i = 7; i >= 0; i--)
         bitXfer(tx[i], rx[i]);
      bitXfer(lastBit, ackSeen);
   endtask
endmodule

`default_nettype wire

// ---- sim/test_thermal_adc_result_regs.sv ----
// Purpose: self-checking bench of the result registers behind the serial port
// Assumes: host model drives the bus; converter results driven by the bench
// Notes:   reference model holds a byte image of the register space

`timescale 1ns/10ps
`default_nettype none

module test_thermal_adc_result_regs;
   logic                      mclk;
   logic                      rstn;
   logic                      regReset;
   thtr_pkg::thtr_result_type resultIn;
   logic                      sclPin;
   logic                      sdaDriveN;
   logic                      sdaLine;
   logic                      sdaOut;
   logic                      sdaOutEnN;
   logic [16:0]               dieTempHalfDeg;
   logic [7:0]                refReg [0:255];
   logic [7:0]                curPtr;
   logic [31:0]               seed;
   int                        failures;
   int                        checksDone;
   int                        cycleCount;

   // ==========================================================
   // clock, bus wiring, instances
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // pull-up: released line reads high
   assign sdaLine = sdaDriveN & (sdaOutEnN | sdaOut);

   thtr_host_model host_u (
      .mclk      (mclk),
      .sdaLine   (sdaLine),
      .sclPin    (sclPin),
      .sdaDriveN (sdaDriveN)
   );

   thtr_result_regs dut_u (
      .mclk           (mclk),
      .rstn           (rstn),
      .regReset       (regReset),
      .resultIn       (resultIn),
      .sclIn          (sclPin),
      .sdaIn          (sdaLine),
      .sdaOut         (sdaOut),
      .sdaOutEnN      (sdaOutEnN),
      .dieTempHalfDeg (dieTempHalfDeg)
   );

   // ==========================================================
   // checking and closing
   task automatic wrap_up();
      $display("checks done %0d, failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   always @(posedge mclk)
   begin
      cycleCount++;
      if (cycleCount == 60000)
      begin
         failures++;
         wrap_up();
      end
   end

   function automatic logic [31:0] nextRand(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // ==========================================================
   // converter side
   task automatic capture(input logic [1:0] ch, input logic [15:0] value, input logic rst);
      resultIn = '{valid: 1'b1, chan: ch, code: value};
      regReset = rst;
      if (rst)
         for (int a = 8'h22; a <= 8'h27; a++)
            refReg[a] = 8'h00;
      else if (ch != 2'h3)
      begin
         refReg[8'h22 + 2 * ch] = value[15:8];
         refReg[8'h23 + 2 * ch] = value[7:0];
      end
      @(negedge mclk);
   endtask

   task automatic settleInputs();
      resultIn.valid = 1'b0;
      regReset = 1'b0;
      repeat (3) @(negedge mclk);
   endtask

   task automatic checkDie();
      int v;
      v = $signed({refReg[8'h26], refReg[8'h27]}) + 10;
      check("dieTempHalfDeg", {15'h0000, dieTempHalfDeg}, {15'h0000, v[16:0]});
   endtask

   // ==========================================================
   // host side
   task automatic addrPhase(input logic [6:0] dev, input logic rw, input logic expAck);
      logic [7:0] rx;
      logic       ack;
      host_u.startCond();
      host_u.xferByte({dev, rw}, 1'b1, rx, ack);
      check("addressAck", {31'h0, ack}, {31'h0, expAck});
   endtask

   task automatic sendByte(input logic [7:0] b);
      logic [7:0] rx;
      logic       ack;
      host_u.xferByte(b, 1'b1, rx, ack);
      check("byteAck", {31'h0, ack}, 32'h0);
   endtask

   task automatic readRegs(input logic setP, input logic [7:0] ptr, input int n);
      logic [7:0] rx;
      logic       ack;
      if (setP)
      begin
         addrPhase(thtr_pkg::THTR_DEV_ADDR, 1'b0, 1'b0);
         sendByte(ptr);
         curPtr = ptr;
      end
      addrPhase(thtr_pkg::THTR_DEV_ADDR, 1'b1, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         host_u.xferByte(8'hff, (i == n - 1), rx, ack);
         check("readByte", {24'h0, rx}, {24'h0, refReg[curPtr]});
         curPtr = curPtr + 8'h01;
      end
      host_u.stopCond();
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      rstn = 1'b0;
      regReset = 1'b0;
      resultIn = '0;
      seed = 32'hecc1;
      for (int a = 0; a < 256; a++)
         refReg[a] = 8'h00;
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      checkDie();
      readRegs(1'b1, thtr_pkg::THTR_OFF_BUS_HI, 6);
      // back-to-back captures, all channel codes including the ignored one
      for (int r = 0; r < 3; r++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            seed = nextRand(seed);
            capture(k[1:0], seed[31:16] | ((k == r) ? 16'h8000 : 16'h0000), 1'b0);
         end
         settleInputs();
         checkDie();
         readRegs(1'b1, thtr_pkg::THTR_OFF_BUS_HI, 6);
      end
      // writes are taken but leave results alone
      addrPhase(thtr_pkg::THTR_DEV_ADDR, 1'b0, 1'b0);
      sendByte(thtr_pkg::THTR_OFF_BUS_HI);
      sendByte(~refReg[8'h22]);
      sendByte(~refReg[8'h23]);
      host_u.stopCond();
      curPtr = thtr_pkg::THTR_OFF_BATT_HI;
      readRegs(1'b0, 8'h00, 1);
      readRegs(1'b1, thtr_pkg::THTR_OFF_BUS_HI, 6);
      // foreign address is not answered
      addrPhase(thtr_pkg::THTR_DEV_ADDR ^ 7'h01, 1'b0, 1'b1);
      host_u.stopCond();
      readRegs(1'b1, 8'hff, 2);
      // soft reset beats a capture in the same cycle
      seed = nextRand(seed);
      capture(thtr_pkg::THTR_CH_DIE, seed[15:0], 1'b1);
      settleInputs();
      checkDie();
      readRegs(1'b1, thtr_pkg::THTR_OFF_BUS_HI, 6);
      wrap_up();
   end
endmodule

`default_nettype wire
